// ### hw/afr_pkg.sv
// Constants and types of the amplifier fault and restart sequencer
package afr_pkg;

    // ****************************************
    // Timebase and restart timing
    // ****************************************
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned FAULT_INDICATOR_OUT_RELEASE_MS = 50;
    localparam int unsigned RESTART_MS = 100;
    localparam int unsigned OPERATE_MS = 150;
    localparam int unsigned MUTE_HOLD_MS = 150;
    localparam int unsigned LIMIT_TAU_MS = 10;
    localparam int unsigned MS_W = 16;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;
    localparam logic [31:0] BAD_ADDR_DATA = 32'hDEAD_BEEF;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [4:0] MASK_RESET = 5'h00;

    // Event bits of status and mask
    localparam int unsigned EV_OC_SHUT = 0;
    localparam int unsigned EV_WINDOW = 1;
    localparam int unsigned EV_UNDERV = 2;
    localparam int unsigned EV_OVERV = 3;
    localparam int unsigned EV_UNBAL = 4;
    localparam int unsigned EV_N = 5;

    // Requested mode
    typedef enum logic [1:0] {
        MODE_STANDBY = 2'b00,
        MODE_MUTE = 2'b01,
        MODE_OPERATE = 2'b10
    } afr_mode_type;

    typedef enum logic [2:0] {
        ST_STANDBY = 3'b000,
        ST_WINDOW = 3'b001,
        ST_MUTE = 3'b010,
        ST_OPERATE = 3'b011,
        ST_OFF = 3'b100
    } afr_state_type;

endpackage

// ### hw/afr_sequencer.sv
// Fault handling and restart sequencer with Avalon-MM register slave
`timescale 1ns/1ps

module afr_sequencer #(
    parameter int unsigned CYC_PER_MS = afr_pkg::CYC_PER_MS,
    parameter int unsigned LIMIT_TAU_MS = afr_pkg::LIMIT_TAU_MS
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] mode_req_i,
    input wire logic overcurrent_guard_i,
    input wire logic load_short_i,
    input wire logic window_fault_i,
    input wire logic undervoltage_guard_i,
    input wire logic overvoltage_guard_i,
    input wire logic supply_unbalance_guard_i,
    input wire logic [3:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic fault_indicator_out_o,
    output logic fault_indicator_oe_o,
    output logic stage_enable_o,
    output logic mute_o,
    output logic audio_enable_o,
    output logic irq_o
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int unsigned NIN = 8;
    logic [NIN-1:0] in_raw;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    assign in_raw = {mode_req_i, overcurrent_guard_i, load_short_i,
        window_fault_i, undervoltage_guard_i, overvoltage_guard_i,
        supply_unbalance_guard_i};

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= in_raw;
            sync2_r <= sync1_r;
        end
    end

    wire [1:0] mode_s = sync2_r[7:6];
    wire limit_s = sync2_r[5];
    wire short_s = sync2_r[4];
    wire win_s = sync2_r[3];
    wire uv_s = sync2_r[2];
    wire ov_s = sync2_r[1];
    wire ub_s = sync2_r[0];

    // ****************************************
    // Millisecond timebase
    // ****************************************
    logic [31:0] cyc_r;
    logic [afr_pkg::MS_W-1:0] ms_r;
    logic [afr_pkg::MS_W-1:0] lim_ms_r;
    logic [31:0] lim_cyc_r;
    wire ms_tick = (cyc_r == CYC_PER_MS - 1);

    // ****************************************
    // Sequencer state
    // ****************************************
    afr_pkg::afr_state_type st_r;
    afr_pkg::afr_state_type st_nxt;
    logic fault_indicator_out_low_r;
    logic fault_indicator_out_low_nxt;
    logic shorted_r;
    logic shorted_nxt;
    logic uv_seen_r;
    logic uv_seen_nxt;
    logic ms_clr;

    wire standby_req = (mode_s == afr_pkg::MODE_STANDBY);
    wire oper_req = (mode_s == afr_pkg::MODE_OPERATE);
    // Escalation from limiting after tau
    wire oc_trip = limit_s && (lim_ms_r >= LIMIT_TAU_MS[afr_pkg::MS_W-1:0]);
    wire blocking = uv_s || ub_s;
    wire active = (st_r == afr_pkg::ST_MUTE) || (st_r == afr_pkg::ST_OPERATE);
    wire ev_oc = active && oc_trip;
    wire ev_uv = active && uv_s;
    wire ev_ub = active && ub_s;
    wire [31:0] ms_restart = afr_pkg::RESTART_MS;
    wire [31:0] ms_fault_indicator_out = afr_pkg::FAULT_INDICATOR_OUT_RELEASE_MS;
    wire [31:0] ms_oper = afr_pkg::OPERATE_MS;
    wire [31:0] ms_mute = afr_pkg::MUTE_HOLD_MS;
    logic [afr_pkg::MS_W-1:0] since_off_r;
    wire restart_due = (since_off_r != '1) && (since_off_r >= ms_oper);

    always_comb begin
        st_nxt = st_r;
        fault_indicator_out_low_nxt = fault_indicator_out_low_r;
        shorted_nxt = shorted_r;
        uv_seen_nxt = uv_seen_r;
        ms_clr = 1'b0;
        case (st_r)
            afr_pkg::ST_STANDBY: begin
                fault_indicator_out_low_nxt = 1'b0;
                if (!standby_req) begin
                    st_nxt = afr_pkg::ST_WINDOW;
                    ms_clr = 1'b1;
                end
            end
            afr_pkg::ST_WINDOW: begin
                // Stages stay off until check passes
                // Window fault at start and restart
                if (standby_req) begin
                    st_nxt = afr_pkg::ST_STANDBY;
                end else if (!win_s && !blocking) begin
                    st_nxt = afr_pkg::ST_MUTE;
                    fault_indicator_out_low_nxt = 1'b0;
                    ms_clr = 1'b1;
                end else if (win_s) begin
                    fault_indicator_out_low_nxt = shorted_r;
                end
            end
            afr_pkg::ST_MUTE, afr_pkg::ST_OPERATE: begin
                if (standby_req) begin
                    st_nxt = afr_pkg::ST_STANDBY;
                end else if (ev_oc || uv_s || ub_s) begin
                    st_nxt = afr_pkg::ST_OFF;
                    fault_indicator_out_low_nxt = ev_oc;
                    shorted_nxt = ev_oc && !short_s;
                    uv_seen_nxt = uv_s;
                    ms_clr = 1'b1;
                end else if (st_r == afr_pkg::ST_MUTE && oper_req &&
                        (ms_r >= ms_mute || restart_due)) begin
                    st_nxt = afr_pkg::ST_OPERATE;
                end else if (st_r == afr_pkg::ST_OPERATE && !oper_req) begin
                    st_nxt = afr_pkg::ST_MUTE;
                end
            end
            afr_pkg::ST_OFF: begin
                if (blocking) begin
                    // Restart waits for all blocking faults
                    ms_clr = 1'b1;
                    uv_seen_nxt = uv_seen_r || uv_s;
                end else begin
                    if (ms_r >= ms_fault_indicator_out && !shorted_r) begin
                        fault_indicator_out_low_nxt = 1'b0;
                    end
                    // Back to window check at 100 ms
                    if (ms_r >= ms_restart) begin
                        st_nxt = afr_pkg::ST_WINDOW;
                        uv_seen_nxt = 1'b0;
                    end
                end
            end
            default: begin
                st_nxt = afr_pkg::ST_STANDBY;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st_r <= afr_pkg::ST_STANDBY;
            fault_indicator_out_low_r <= 1'b0;
            shorted_r <= 1'b0;
            uv_seen_r <= 1'b0;
            cyc_r <= '0;
            ms_r <= '0;
        end else begin
            st_r <= st_nxt;
            fault_indicator_out_low_r <= fault_indicator_out_low_nxt;
            shorted_r <= (st_nxt == afr_pkg::ST_OPERATE) ? 1'b0 : shorted_nxt;
            uv_seen_r <= uv_seen_nxt;
            // Single ms counter, cleared at shutdown
            if (ms_clr) begin
                cyc_r <= '0;
                ms_r <= '0;
            end else if (ov_s) begin
                cyc_r <= cyc_r;
            end else if (ms_tick) begin
                cyc_r <= '0;
                if (ms_r != '1) begin
                    ms_r <= ms_r + 1'b1;
                end
            end else begin
                cyc_r <= cyc_r + 1;
            end
        end
    end

    // Limiting duration counter
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lim_cyc_r <= '0;
            lim_ms_r <= '0;
        end else if (!limit_s || !active) begin
            // Restart tau for each limiting episode
            lim_cyc_r <= '0;
            lim_ms_r <= '0;
        end else if (lim_cyc_r == CYC_PER_MS - 1) begin
            lim_cyc_r <= '0;
            if (lim_ms_r != '1) begin
                lim_ms_r <= lim_ms_r + 1'b1;
            end
        end else begin
            lim_cyc_r <= lim_cyc_r + 1;
        end
    end

    // Mute to operate after restart at 150 ms total
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            since_off_r <= '1;
        end else if (ms_clr && st_nxt == afr_pkg::ST_OFF) begin
            since_off_r <= '0;
        end else if (st_r == afr_pkg::ST_STANDBY) begin
            since_off_r <= '1;
        end else if (ms_tick && !ov_s && since_off_r != '1) begin
            since_off_r <= since_off_r + 1'b1;
        end
    end

    // ****************************************
    // Output stage control
    // ****************************************
    // Overvoltage gates stages without restart timer
    // Mute switches at 50 %, standby off
    wire in_mute = (st_r == afr_pkg::ST_MUTE);
    wire in_oper = (st_r == afr_pkg::ST_OPERATE);
    wire stage_nxt = (in_mute || in_oper) && !ov_s;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            stage_enable_o <= 1'b0;
            mute_o <= 1'b1;
            audio_enable_o <= 1'b0;
            fault_indicator_out_o <= 1'b0;
            fault_indicator_oe_o <= 1'b0;
        end else begin
            stage_enable_o <= stage_nxt;
            mute_o <= !in_oper;
            audio_enable_o <= in_oper && !ov_s;
            // Open drain: only ever pulls low
            fault_indicator_out_o <= 1'b0;
            fault_indicator_oe_o <= fault_indicator_out_low_nxt;
        end
    end

    // ****************************************
    // Register slave
    // ****************************************
    // Control: two spare bits, stored only, no effect on sequencing
    logic [1:0] ctrl_r;
    logic [afr_pkg::EV_N-1:0] ist_r;
    logic [afr_pkg::EV_N-1:0] imask_r;
    logic ack_r;
    wire req = (avs_read_i || avs_write_i) && !ack_r;
    wire [afr_pkg::EV_N-1:0] ev = {ev_ub, ov_s && active, ev_uv,
        win_s && st_r == afr_pkg::ST_WINDOW, ev_oc};
    wire wr = ack_r && avs_write_i;
    wire [afr_pkg::EV_N-1:0] w1c = (wr && avs_address_i ==
        afr_pkg::ADDR_IRQ_STAT) ? avs_writedata_i[afr_pkg::EV_N-1:0] : '0;
    wire [31:0] status_word = {23'h0, since_off_r >= ms_oper, uv_seen_r,
        shorted_r, fault_indicator_out_low_r, st_r, mode_s};
    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address_i)
            afr_pkg::ADDR_CTRL: rd_mux = {30'h0, ctrl_r};
            afr_pkg::ADDR_STATUS: rd_mux = status_word;
            afr_pkg::ADDR_IRQ_STAT: rd_mux = {27'h0, ist_r};
            afr_pkg::ADDR_IRQ_MASK: rd_mux = {27'h0, imask_r};
            default: rd_mux = afr_pkg::BAD_ADDR_DATA;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= afr_pkg::CTRL_RESET;
            imask_r <= afr_pkg::MASK_RESET;
            ist_r <= '0;
            ack_r <= 1'b0;
            avs_readdata_o <= '0;
            irq_o <= 1'b0;
        end else begin
            ack_r <= req;
            if (req) begin
                avs_readdata_o <= rd_mux;
            end
            if (wr && avs_address_i == afr_pkg::ADDR_CTRL) begin
                ctrl_r <= avs_writedata_i[1:0];
            end
            if (wr && avs_address_i == afr_pkg::ADDR_IRQ_MASK) begin
                imask_r <= avs_writedata_i[afr_pkg::EV_N-1:0];
            end
            // Set wins over clear
            ist_r <= (ist_r & ~w1c) | ev;
            irq_o <= |(((ist_r & ~w1c) | ev) & imask_r);
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            avs_waitrequest_o <= 1'b1;
        end else begin
            avs_waitrequest_o <= !req;
        end
    end

endmodule

// ### dv/afr_chk.sv
// Port assertions of the fault and restart sequencer
`timescale 1ns/1ps
module afr_chk #(
    parameter int unsigned CYC_PER_MS = 10
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [1:0] mode_req_i,
    input wire logic load_short_i,
    input wire logic window_fault_i,
    input wire logic undervoltage_guard_i,
    input wire logic overvoltage_guard_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic avs_waitrequest_o,
    input wire logic fault_indicator_oe_o,
    input wire logic stage_enable_o,
    input wire logic mute_o,
    input wire logic audio_enable_o
);
    localparam int unsigned SAT = 100000;
    localparam int unsigned T48 = CYC_PER_MS * 48;
    localparam int unsigned T52 = CYC_PER_MS * 52;
    localparam int unsigned T98 = CYC_PER_MS * 98;
    localparam int unsigned T148 = CYC_PER_MS * 148;
    // ****************************************
    // Cycles since shutdown and since undervoltage
    // ****************************************
    int unsigned off_cnt_r;
    int unsigned uv_cnt_r;
    logic oe_d_r;
    logic stg_d_r;
    // Only a trip from running counts, not a start-up window fault
    wire shut_now = fault_indicator_oe_o && !oe_d_r && stg_d_r;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            off_cnt_r <= SAT;
            uv_cnt_r <= SAT;
            oe_d_r <= 1'b0;
            stg_d_r <= 1'b0;
        end else begin
            oe_d_r <= fault_indicator_oe_o;
            stg_d_r <= stage_enable_o;
            off_cnt_r <= shut_now ? 1 : (off_cnt_r < SAT ? off_cnt_r + 1 : SAT);
            uv_cnt_r <= undervoltage_guard_i ? 0 :
                (uv_cnt_r < SAT ? uv_cnt_r + 1 : SAT);
        end
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_wait;
        $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer late");
    property p_wpulse;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wpulse: assert property (p_wpulse) else $error("answer too long");
    property p_stby;
        (mode_req_i == 2'h0) [*5] |-> !stage_enable_o;
    endproperty
    a_stby: assert property (p_stby) else $error("stage on in standby");
    property p_audio;
        audio_enable_o |-> stage_enable_o && !mute_o;
    endproperty
    a_audio: assert property (p_audio) else $error("audio while muted");
    property p_ov;
        overvoltage_guard_i [*4] |-> !stage_enable_o;
    endproperty
    a_ov: assert property (p_ov) else $error("stage on in overvoltage");
    property p_win;
        $rose(stage_enable_o) |-> !$past(window_fault_i, 2);
    endproperty
    a_win: assert property (p_win) else $error("stage on with short");
    property p_off;
        stage_enable_o |-> off_cnt_r >= T98;
    endproperty
    a_off: assert property (p_off) else $error("mute before 100 ms");
    property p_oper;
        !mute_o |-> off_cnt_r >= T148;
    endproperty
    a_oper: assert property (p_oper) else $error("operate too soon");
    property p_fault_indicator_out;
        $fell(fault_indicator_oe_o) && load_short_i |->
            off_cnt_r inside {[T48:T52]};
    endproperty
    a_fault_indicator_out: assert property (p_fault_indicator_out) else $error("release not 50 ms");
    property p_uv;
        stage_enable_o && uv_cnt_r > 5 |-> uv_cnt_r >= T98;
    endproperty
    a_uv: assert property (p_uv) else $error("early undervolt restart");
    c_trip: cover property (shut_now);
    c_rel: cover property ($fell(fault_indicator_oe_o) && load_short_i);
    c_run: cover property ($fell(mute_o));
endmodule
bind afr_sequencer afr_chk #(.CYC_PER_MS(CYC_PER_MS)) i_chk (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .mode_req_i(mode_req_i),
    .load_short_i(load_short_i), .window_fault_i(window_fault_i),
    .undervoltage_guard_i(undervoltage_guard_i),
    .overvoltage_guard_i(overvoltage_guard_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
    .fault_indicator_oe_o(fault_indicator_oe_o),
    .stage_enable_o(stage_enable_o), .mute_o(mute_o),
    .audio_enable_o(audio_enable_o));

// ### dv/afr_host_model.sv
// Host that reads the fault indicator line and classifies it
`timescale 1ns/1ps
module afr_host_model #(
    parameter int unsigned LONG_LOW = 700
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic line_i,
    output logic supply_short_o,
    output logic load_short_o
);
    int unsigned low_cnt_r;
    logic [1:0] falls_r;
    logic line_d_r;
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_r <= 0;
            falls_r <= 2'h0;
            line_d_r <= 1'b1;
            supply_short_o <= 1'b0;
            load_short_o <= 1'b0;
        end else begin
            line_d_r <= line_i;
            low_cnt_r <= line_i ? 0 : low_cnt_r + 1;
            supply_short_o <= low_cnt_r > LONG_LOW;
            if (line_d_r && !line_i && falls_r != 2'h3) begin
                falls_r <= falls_r + 2'h1;
            end
            load_short_o <= falls_r >= 2'h2 && low_cnt_r <= LONG_LOW;
        end
    end
endmodule

// ### dv/amp_fault_restart_sequencer_tb.sv
// Self-checking bench of the fault and restart sequencer
`timescale 1ns/1ps
module amp_fault_restart_sequencer_tb;
    localparam int CYC = 10;
    localparam int TAU = 2;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] mode = 2'h0;
    logic oc = 1'b0;
    logic ls = 1'b0;
    logic win = 1'b0;
    logic uv = 1'b0;
    logic ov = 1'b0;
    logic ub = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic wreq, f_out, f_oe, stg, mute, aud, irq, h_sup, h_load;
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'h057cf37b;
    int t;
    int k;
    // No pull-up on the pin: the host's level shifter reads released as high
    wire line = f_oe ? f_out : 1'b1;
    always #2.5 clk = ~clk;
    afr_sequencer #(.CYC_PER_MS(CYC), .LIMIT_TAU_MS(TAU)) i_dut (
        .ref_clk_i(clk), .resetn_i(rst_n), .mode_req_i(mode),
        .overcurrent_guard_i(oc), .load_short_i(ls), .window_fault_i(win),
        .undervoltage_guard_i(uv), .overvoltage_guard_i(ov),
        .supply_unbalance_guard_i(ub), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
        .fault_indicator_out_o(f_out), .fault_indicator_oe_o(f_oe),
        .stage_enable_o(stg), .mute_o(mute), .audio_enable_o(aud),
        .irq_o(irq));
    afr_host_model #(.LONG_LOW(70 * CYC)) i_host (.ref_clk_i(clk),
        .resetn_i(rst_n), .line_i(line), .supply_short_o(h_sup),
        .load_short_o(h_load));
    // ****************************************
    // Tasks and expectations
    // ****************************************
    function automatic int ms(input int m);
        return m * CYC;
    endfunction
    function automatic logic [31:0] irq_bit(input int e);
        return 32'h1 << e;
    endfunction
    task automatic conclude();
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= d;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (wreq === 1'b0) break;
        end
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (i == 20) begin
            n_mismatch++;
            conclude();
        end
    endtask
    // Bit 0 stage, bit 1 indicator enable, bit 2 audio; t counts the wait
    task automatic waitfor(input int b, input logic v, input int lim);
        logic [2:0] m;
        for (t = 0; t < lim; t++) begin
            @(posedge clk);
            m = {aud, f_oe, stg};
            if (m[b] === v) break;
        end
        if (t == lim) begin
            n_mismatch++;
            conclude();
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        chk("reset", {aud, stg, mute, f_oe, irq}, 5'h04);
        rst_n <= 1'b1;
        bus(0, afr_pkg::ADDR_IRQ_MASK, 32'h0);
        chk("mask", q, {27'h0, afr_pkg::MASK_RESET});
        bus(0, afr_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", q, {30'h0, afr_pkg::CTRL_RESET});
        bus(1, 4'h2, 32'hFFFF_FFFF);
        bus(0, 4'h2, 32'h0);
        chk("unmapped", q, afr_pkg::BAD_ADDR_DATA);
        bus(1, afr_pkg::ADDR_IRQ_MASK, 32'h1F);
        win <= 1'b1;
        mode <= 2'h2;
        repeat (100) @(posedge clk);
        chk("win_block", stg, 1'b0);
        win <= 1'b0;
        waitfor(0, 1'b1, 100);
        waitfor(2, 1'b1, ms(160));
        chk("mute_hold", t >= ms(148), 1);
        // Pulses kept below one tick of the limit timer
        repeat (20) begin
            oc <= 1'b1;
            repeat (3 + $unsigned($random(seed)) % 6) @(posedge clk);
            oc <= 1'b0;
            repeat (30) @(posedge clk);
        end
        chk("limit", {stg, f_oe}, 2'h2);
        ls <= 1'b1;
        oc <= 1'b1;
        waitfor(1, 1'b1, ms(TAU + 2));
        // Stage follows the indicator one cycle later
        @(posedge clk);
        chk("trip", stg, 1'b0);
        waitfor(1, 1'b0, ms(52));
        chk("release", t >= ms(48), 1);
        waitfor(0, 1'b1, ms(52));
        waitfor(1, 1'b1, ms(TAU + 2));
        @(posedge clk);
        chk("retrip", stg, 1'b0);
        waitfor(1, 1'b0, ms(52));
        chk("host_load", h_load, 1'b1);
        bus(0, afr_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("irq_oc", {q[afr_pkg::EV_OC_SHUT], irq}, 2'h3);
        oc <= 1'b0;
        ls <= 1'b0;
        waitfor(2, 1'b1, ms(300));
        // Release came at 50 ms, so operation is due 100 ms later
        chk("oper_150", t >= ms(96) && t <= ms(102), 1);
        bus(1, afr_pkg::ADDR_IRQ_STAT, 32'h1F);
        repeat (3) @(posedge clk);
        chk("irq_clr", irq, 1'b0);
        oc <= 1'b1;
        win <= 1'b1;
        waitfor(1, 1'b1, ms(TAU + 2));
        oc <= 1'b0;
        repeat (ms(200)) @(posedge clk);
        chk("sup_short", {stg, f_oe, h_sup}, 3'h3);
        win <= 1'b0;
        waitfor(1, 1'b0, 20);
        waitfor(2, 1'b1, ms(200));
        bus(1, afr_pkg::ADDR_IRQ_MASK, 32'h0);
        for (k = 0; k < 2; k++) begin
            {ub, uv} <= k ? 2'h2 : 2'h1;
            repeat (20) @(posedge clk);
            chk("guard_off", {stg, irq}, 2'h0);
            {ub, uv} <= 2'h0;
            waitfor(0, 1'b1, ms(120));
            chk("guard_wait", t >= ms(96), 1);
            waitfor(2, 1'b1, ms(200));
        end
        bus(0, afr_pkg::ADDR_IRQ_STAT, 32'h0);
        chk("ev_uv", q[afr_pkg::EV_UNDERV], 1'b1);
        bus(1, afr_pkg::ADDR_IRQ_MASK, irq_bit(afr_pkg::EV_UNBAL));
        repeat (3) @(posedge clk);
        chk("irq_mask", irq, 1'b1);
        bus(1, afr_pkg::ADDR_IRQ_STAT, irq_bit(afr_pkg::EV_UNBAL));
        repeat (3) @(posedge clk);
        chk("irq_w1c", irq, 1'b0);
        ov <= 1'b1;
        repeat (20) @(posedge clk);
        chk("ov_off", {aud, stg}, 2'h0);
        ov <= 1'b0;
        waitfor(2, 1'b1, 10);
        chk("ov_back", stg, 1'b1);
        {ov, uv} <= 2'h3;
        repeat (20) @(posedge clk);
        uv <= 1'b0;
        repeat (ms(30)) @(posedge clk);
        chk("multi_hold", stg, 1'b0);
        ov <= 1'b0;
        waitfor(0, 1'b1, ms(120));
        chk("multi_wait", t >= ms(96), 1);
        mode <= 2'h0;
        repeat (10) @(posedge clk);
        chk("standby", {stg, mute, aud}, 3'h2);
        conclude();
    end
endmodule
